// ---- verilog/sieb_defines.svh ----
// Constants for the interrupt enable register bank
`ifndef SIEB_DEFINES_SVH
`define SIEB_DEFINES_SVH

`define SIEB_ADDR_W 4
`define SIEB_OFS_FIRST 4'h0
`define SIEB_OFS_SECOND 4'h1
`define SIEB_BIT_WDOG 0
`define SIEB_BIT_OSC 1
`define SIEB_BIT_NMI 4
`define SIEB_BIT_FLASH 5
`define SIEB_BIT_RX 6
`define SIEB_BIT_TX 7
`define SIEB_BIT_BTIM 7
`define SIEB_MASK_FIRST 8'hf3
`define SIEB_MASK_SECOND 8'h80
`define SIEB_RESET_VAL 8'h00
`define SIEB_NUM_SRC 7

`endif

// ---- verilog/sieb_pkg.sv ----
// Types shared by the interrupt enable register bank
package sieb_pkg;

    // Pending flags, or requests, one bit per source
    typedef struct packed {
        logic base_timer;
        logic serial_tx;
        logic serial_rx;
        logic flash_violation;
        logic nonmaskable_pin;
        logic osc_fault;
        logic watchdog;
    } sieb_src_s;

    // Byte-wide CPU access
    typedef struct packed {
        logic [3:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sieb_acc_s;

endpackage : sieb_pkg

// ---- verilog/sieb_gate.sv ----
// Per-source request gate: registered AND of flag and enable
`timescale 1ns/1ps
`include "sieb_defines.svh"
module sieb_gate (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Flags and enables
    input wire logic [6:0] pend,
    input wire logic [6:0] en,
    // Gated requests
    output logic [6:0] req
);

    // One flop per source
    genvar i;
    generate
        for (i = 0; i < `SIEB_NUM_SRC; i++)
        begin : g_src
            always_ff @(posedge clock or negedge resetn)
            begin
                if (!resetn)
                    req[i] <= 1'b0;
                else
                    req[i] <= pend[i] & en[i];
            end
        end
    endgenerate

endmodule : sieb_gate

// ---- verilog/sieb_bank.sv ----
// Interrupt enable register bank at the bottom of the byte space
// What this block does
// - Byte 0: tx bit7, rx bit6, flash bit5, nmi bit4, osc bit1, wdog bit0.
// - Watchdog enable only gates requests in interval timer mode.
// - Receive enable gates receive request in both serial modes.
// - Transmit enable gates transmit request in both serial modes.
// - Byte 1 bit 7 enables the base timer request.
// - Unassigned bits hold no storage and ignore writes.
// - Fault, nmi, flash requests blocked only by their own enable.
`timescale 1ns/1ps
`include "sieb_defines.svh"
module sieb_bank (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // CPU byte access
    input wire sieb_pkg::sieb_acc_s acc,
    output logic [7:0] rdata,
    // Watchdog mode: high when interval timer
    input wire logic wdog_interval_mode,
    // Source pending flags
    input wire sieb_pkg::sieb_src_s pend,
    // Requests to the CPU
    output sieb_pkg::sieb_src_s req
);

    logic [7:0] first_r;
    logic [7:0] second_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [6:0] req_bits;

    // Address decode
    wire sel_first = acc.addr == `SIEB_OFS_FIRST;
    wire sel_second = acc.addr == `SIEB_OFS_SECOND;
    wire wr_first = acc.wr & sel_first;
    wire wr_second = acc.wr & sel_second;

    // Enable registers; absent bits never stored
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            first_r <= `SIEB_RESET_VAL;
            second_r <= `SIEB_RESET_VAL;
        end
        else
        begin
            if (wr_first)
                first_r <= acc.wdata & `SIEB_MASK_FIRST;
            if (wr_second)
                second_r <= acc.wdata & `SIEB_MASK_SECOND;
        end
    end

    // Read mux; unmapped bytes read zero
    assign rdata_nxt = sel_first ? first_r :
                       sel_second ? second_r : `SIEB_RESET_VAL;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            rdata_r <= `SIEB_RESET_VAL;
        else if (acc.rd)
            rdata_r <= rdata_nxt;
    end
    assign rdata = rdata_r;

    // Effective enables in source order
    wire wdog_en = first_r[`SIEB_BIT_WDOG] & wdog_interval_mode;
    wire [6:0] en_vec = {
        second_r[`SIEB_BIT_BTIM],
        first_r[`SIEB_BIT_TX],
        first_r[`SIEB_BIT_RX],
        first_r[`SIEB_BIT_FLASH],
        first_r[`SIEB_BIT_NMI],
        first_r[`SIEB_BIT_OSC],
        wdog_en
    };

    // Registered gating of every source
    sieb_gate u_gate (
        .clock(clock),
        .resetn(resetn),
        .pend(pend),
        .en(en_vec),
        .req(req_bits)
    );
    assign req = req_bits;

    // Storage never holds unassigned bits
    chk_absent_bits_zero: assert property (@(posedge clock)
        disable iff (!resetn)
        (first_r & ~`SIEB_MASK_FIRST) == 8'h00 &&
        (second_r & ~`SIEB_MASK_SECOND) == 8'h00)
        else $error("unassigned enable bit stored");

    // Write to byte 0 lands next cycle
    chk_first_write: assert property (@(posedge clock)
        disable iff (!resetn)
        wr_first |=> first_r == ($past(acc.wdata) & `SIEB_MASK_FIRST))
        else $error("first enable write lost");

    // Write to byte 1 lands next cycle
    chk_second_write: assert property (@(posedge clock)
        disable iff (!resetn)
        wr_second |=> second_r[`SIEB_BIT_BTIM] ==
            $past(acc.wdata[`SIEB_BIT_BTIM]))
        else $error("second enable write lost");

    // Watchdog request silent in watchdog mode
    chk_wdog_mode: assert property (@(posedge clock)
        disable iff (!resetn)
        !wdog_interval_mode |=> !req.watchdog)
        else $error("watchdog request in reset mode");

    // Watchdog request is flag and enable in interval mode
    chk_wdog_pass: assert property (@(posedge clock)
        disable iff (!resetn)
        wdog_interval_mode |=>
        req.watchdog == $past(pend.watchdog & first_r[`SIEB_BIT_WDOG]))
        else $error("watchdog request mismatch in interval mode");

    // Cleared watchdog enable blocks its request in any mode
    chk_wdog_block: assert property (@(posedge clock)
        disable iff (!resetn)
        !first_r[`SIEB_BIT_WDOG] |=> !req.watchdog)
        else $error("watchdog request leaked past enable");

    // Receive follows flag and enable
    chk_rx_gate: assert property (@(posedge clock)
        disable iff (!resetn)
        1'b1 |=>
        req.serial_rx == $past(pend.serial_rx & first_r[`SIEB_BIT_RX]))
        else $error("receive request mismatch");

    // Transmit follows flag and enable
    chk_tx_gate: assert property (@(posedge clock)
        disable iff (!resetn)
        1'b1 |=>
        req.serial_tx == $past(pend.serial_tx & first_r[`SIEB_BIT_TX]))
        else $error("transmit request mismatch");

    // Cleared enable blocks fault sources
    chk_fault_block: assert property (@(posedge clock)
        disable iff (!resetn)
        (!first_r[`SIEB_BIT_OSC] && !first_r[`SIEB_BIT_NMI] &&
        !first_r[`SIEB_BIT_FLASH]) |=>
        !(req.osc_fault | req.nonmaskable_pin | req.flash_violation))
        else $error("fault request leaked past enable");

    // Oscillator fault request follows its own enable only
    chk_osc_gate: assert property (@(posedge clock)
        disable iff (!resetn)
        1'b1 |=>
        req.osc_fault == $past(pend.osc_fault & first_r[`SIEB_BIT_OSC]))
        else $error("oscillator fault request mismatch");

    // Nonmaskable request follows its own enable only
    chk_nmi_gate: assert property (@(posedge clock)
        disable iff (!resetn)
        1'b1 |=> req.nonmaskable_pin ==
            $past(pend.nonmaskable_pin & first_r[`SIEB_BIT_NMI]))
        else $error("nonmaskable request mismatch");

    // Flash violation request follows its own enable only
    chk_flash_gate: assert property (@(posedge clock)
        disable iff (!resetn)
        1'b1 |=> req.flash_violation ==
            $past(pend.flash_violation & first_r[`SIEB_BIT_FLASH]))
        else $error("flash violation request mismatch");

    // Base timer request is flag and enable
    chk_btim_gate: assert property (@(posedge clock)
        disable iff (!resetn)
        (pend.base_timer && second_r[`SIEB_BIT_BTIM]) |=> req.base_timer)
        else $error("base timer request missing");

    // Cleared base timer enable blocks its request
    chk_btim_block: assert property (@(posedge clock)
        disable iff (!resetn)
        !second_r[`SIEB_BIT_BTIM] |=> !req.base_timer)
        else $error("base timer request leaked past enable");

    // Byte 0 read returns the stored enables
    chk_first_read: assert property (@(posedge clock)
        disable iff (!resetn)
        (acc.rd && sel_first) |=> rdata == $past(first_r))
        else $error("first enable read mismatch");

    // Byte 1 read returns the stored enable
    chk_second_read: assert property (@(posedge clock)
        disable iff (!resetn)
        (acc.rd && sel_second) |=> rdata == $past(second_r))
        else $error("second enable read mismatch");

    // Unmapped bytes read as zero
    chk_unmapped_read: assert property (@(posedge clock)
        disable iff (!resetn)
        (acc.rd && !sel_first && !sel_second) |=>
        rdata == `SIEB_RESET_VAL)
        else $error("unmapped byte read not zero");

    // Read data holds between reads
    chk_rdata_hold: assert property (@(posedge clock)
        disable iff (!resetn)
        !acc.rd |=> $stable(rdata))
        else $error("read data changed without a read");

    // Byte 0 changes only on its own write
    chk_first_hold: assert property (@(posedge clock)
        disable iff (!resetn)
        !wr_first |=> $stable(first_r))
        else $error("first enable changed without a write");

    // Byte 1 changes only on its own write
    chk_second_hold: assert property (@(posedge clock)
        disable iff (!resetn)
        !wr_second |=> $stable(second_r))
        else $error("second enable changed without a write");

endmodule : sieb_bank

// ---- test/sieb_cpu.sv ----
// CPU model making byte accesses to the enable bank
`timescale 1ns/1ps
module sieb_cpu (
    // Clock
    input wire logic clock,
    // Byte access and read data
    output sieb_pkg::sieb_acc_s acc,
    input wire logic [7:0] rdata
);
    initial acc = '0;
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 acc = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clock);
        #1 acc.wr = 1'b0;
    endtask : wr
    // One-cycle read strobe, data registered at the taking edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        #1 acc = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clock);
        #1 acc.rd = 1'b0;
        d = rdata;
    endtask : rd
endmodule : sieb_cpu

// ---- test/sieb_bank_bench.sv ----
// Self-checking bench for the interrupt enable bank
`timescale 1ns/1ps
module sieb_bank_bench;
    logic clock;
    logic resetn;
    logic wdog_interval_mode;
    sieb_pkg::sieb_acc_s acc;
    sieb_pkg::sieb_src_s pend;
    sieb_pkg::sieb_src_s req;
    logic [7:0] rdata;
    logic [7:0] v;
    int n_errors = 0;
    int n_tests = 0;
    sieb_bank u_dut (.clock(clock), .resetn(resetn), .acc(acc),
        .rdata(rdata), .wdog_interval_mode(wdog_interval_mode),
        .pend(pend), .req(req));
    sieb_cpu u_cpu (.clock(clock), .acc(acc), .rdata(rdata));
    // Clock, 25 ns period
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Compare seen against expected
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    // Read a byte and compare
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        u_cpu.rd(a, v);
        check(v, exp);
    endtask : rchk
    // Counts and verdict
    task automatic end_sim;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    // Hang guard
    initial
    begin
        #100000;
        n_errors++;
        end_sim();
    end
    // Main sequence
    initial
    begin
        resetn = 1'b0;
        wdog_interval_mode = 1'b0;
        pend = '0;
        repeat (4) @(posedge clock);
        #1 resetn = 1'b1;
        rchk(4'h0, 8'h00);
        rchk(4'h1, 8'h00);
        u_cpu.wr(4'h0, 8'hff);
        u_cpu.wr(4'h1, 8'hff);
        u_cpu.wr(4'h2, 8'hff);
        rchk(4'h0, 8'hf3);
        rchk(4'h1, 8'h80);
        rchk(4'h2, 8'h00);
        pend = 7'h7f;
        repeat (2) @(posedge clock);
        #1 check({1'b0, req}, 8'h7e);
        wdog_interval_mode = 1'b1;
        repeat (2) @(posedge clock);
        #1 check({1'b0, req}, 8'h7f);
        // Walk one enable bit, spare bits included
        for (int i = 0; i < 8; i++)
        begin
            u_cpu.wr(4'h0, 8'h01 << i);
            v = 8'h01 << i;
            repeat (2) @(posedge clock);
            #1 check({1'b0, req}, {2'b01, v[7:4], v[1:0]});
        end
        // Clear byte 1: base timer request must drop
        u_cpu.wr(4'h1, 8'h7f);
        repeat (2) @(posedge clock);
        #1 check({1'b0, req}, 8'h20);
        rchk(4'h1, 8'h00);
        pend = '0;
        repeat (2) @(posedge clock);
        #1 check({1'b0, req}, 8'h00);
        // Reset in mid-run clears both enable bytes
        u_cpu.wr(4'h1, 8'h80);
        resetn = 1'b0;
        repeat (2) @(posedge clock);
        #1 resetn = 1'b1;
        rchk(4'h0, 8'h00);
        rchk(4'h1, 8'h00);
        end_sim();
    end
endmodule : sieb_bank_bench
